/* core/sac_conv_clk.sv */
`timescale 1ns/100ps
`include "sac_cfg.svh"
// ****************************************************************
// Conversion clock half-period tick generator
// ****************************************************************
module sac_conv_clk #(
  parameter int CNT_W = 6
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire logic [2:0] clkSel,
  input wire logic rcClkPin,
  output logic halfTick
);
  logic rcSync1_q, rcSync2_q, rcPrev_q;
  logic [CNT_W-1:0] cnt_q, cnt_d, halfLen;
  logic isRc, rcEdge, divHit;

  // Half-period length for each system clock divider
  assign halfLen = (clkSel == sac_pkg::SAC_CLK_DIV2) ? CNT_W'(`SAC_HALF_DIV2) :
                   (clkSel == sac_pkg::SAC_CLK_DIV4) ? CNT_W'(`SAC_HALF_DIV4) :
                   (clkSel == sac_pkg::SAC_CLK_DIV8) ? CNT_W'(`SAC_HALF_DIV8) :
                   (clkSel == sac_pkg::SAC_CLK_DIV16) ? CNT_W'(`SAC_HALF_DIV16) :
                   (clkSel == sac_pkg::SAC_CLK_DIV32) ? CNT_W'(`SAC_HALF_DIV32) :
                   CNT_W'(`SAC_HALF_DIV64);
  assign isRc = (clkSel[1:0] == 2'h3);
  // Both edges of the RC clock mark a half period
  assign rcEdge = rcSync2_q ^ rcPrev_q;
  assign divHit = (cnt_q == halfLen - CNT_W'(1));
  // Counter restarts when idle so the first half period is full length
  assign cnt_d = (!run || divHit) ? '0 : cnt_q + CNT_W'(1);

  // RC clock pin synchroniser, edge taken from the second stage only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rcSync1_q <= 1'b0;
      rcSync2_q <= 1'b0;
      rcPrev_q <= 1'b0;
    end else begin
      rcSync1_q <= rcClkPin;
      rcSync2_q <= rcSync1_q;
      rcPrev_q <= rcSync2_q;
    end
  end

  // Divider and registered tick
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
      halfTick <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      halfTick <= run && (isRc ? rcEdge : divHit);
    end
  end
endmodule // sac_conv_clk

/* core/sac_sar_seq.sv */
`timescale 1ns/100ps
`include "sac_cfg.svh"
// ****************************************************************
// Successive-approximation sequencer
// ****************************************************************
module sac_sar_seq (
  input wire logic clk,
  input wire logic rst,
  input wire logic halfTick,
  input wire logic cmpAbove,
  sac_seq_if.seq port
);
  sac_pkg::sac_state_e state_q, state_d;
  logic [3:0] bitIdx_q;
  logic [1:0] setupCnt_q;
  logic lastBit_q;
  logic [9:0] lowMask;

  // Mask of bit positions not yet decided
  function automatic logic [9:0] undecided(input logic [3:0] idx);
    undecided = 10'((11'h002 << idx) - 11'h001);
  endfunction

  assign lowMask = undecided(bitIdx_q);
  assign port.busy = (state_q != sac_pkg::SAC_IDLE);

  // Next state: setup for 1.5 periods, then try and decide per bit
  always_comb begin
    state_d = state_q;
    case (state_q)
      sac_pkg::SAC_IDLE: begin
        if (port.start) state_d = sac_pkg::SAC_SETUP;
      end
      sac_pkg::SAC_SETUP: begin
        if (halfTick && setupCnt_q == 2'(`SAC_SETUP_HALVES - 1)) state_d = sac_pkg::SAC_TRY;
      end
      sac_pkg::SAC_TRY: begin
        if (halfTick) state_d = sac_pkg::SAC_DECIDE;
      end
      default: begin
        if (halfTick) state_d = (bitIdx_q == 4'h0) ? sac_pkg::SAC_IDLE : sac_pkg::SAC_TRY;
      end
    endcase
    if (port.abort || port.stop) state_d = sac_pkg::SAC_IDLE;
  end

  // State, counters and trial register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= sac_pkg::SAC_IDLE;
      bitIdx_q <= 4'h9;
      setupCnt_q <= 2'h0;
      lastBit_q <= 1'b0;
      port.trial <= 10'h000;
    end else begin
      state_q <= state_d;
      if (state_q == sac_pkg::SAC_IDLE) begin
        bitIdx_q <= 4'(`SAC_RES_BITS - 1);
        setupCnt_q <= 2'h0;
        lastBit_q <= 1'b0;
        if (port.start) port.trial <= 10'h000;
      end else if (halfTick) begin
        if (state_q == sac_pkg::SAC_SETUP) setupCnt_q <= setupCnt_q + 2'h1;
        if (state_q == sac_pkg::SAC_TRY) port.trial[bitIdx_q] <= 1'b1;
        if (state_q == sac_pkg::SAC_DECIDE) begin
          port.trial[bitIdx_q] <= cmpAbove;
          lastBit_q <= cmpAbove;
          if (bitIdx_q != 4'h0) bitIdx_q <= bitIdx_q - 4'h1;
        end
      end
    end
  end

  // Result hand-off on completion or early stop
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      port.result <= 10'h000;
      port.resultLoad <= 1'b0;
      port.complete <= 1'b0;
    end else begin
      port.resultLoad <= 1'b0;
      port.complete <= 1'b0;
      if (port.stop && port.busy && !port.abort) begin
        port.result <= (port.trial & ~lowMask) | (lastBit_q ? lowMask : 10'h000);
        port.resultLoad <= 1'b1;
      end else if (!port.abort && state_q == sac_pkg::SAC_DECIDE && halfTick &&
                   bitIdx_q == 4'h0) begin
        port.result <= {port.trial[9:1], cmpAbove};
        port.resultLoad <= 1'b1;
        port.complete <= 1'b1;
      end
    end
  end
endmodule // sac_sar_seq

/* core/sac_top.sv */
`timescale 1ns/100ps
`include "sac_cfg.svh"
module sac_top #(
  parameter int ADDR_W = 8,
  parameter int TRG_SRC = 15
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [TRG_SRC:1] trigSrc,
  input wire logic sleepMode,
  input wire logic convIntEnable,
  input wire logic rcClkPin,
  input wire logic cmpAbove,
  output logic [9:0] dacTrial,
  output logic [4:0] channelSel,
  output logic channelConnected,
  output logic [1:0] posRefSel,
  output logic refValid,
  output logic analogPowered,
  output logic sampleHold,
  output logic convDoneFlag,
  output logic wakeReq
);
  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [7:0] ctrl0_q, ctrl0_d, ctrl1_q, ctrl1_d, ctrl2_q, ctrl2_d;
  logic [7:0] resHigh_q, resLow_q, resHigh_d, resLow_d;
  logic flag_q, flag_d, sleepOff_q, sleepOff_d;
  logic trigPrev_q, auto_trigger_sel, trigEdge;
  logic apbDo, apbSetup, wrEn;
  logic hitC0, hitC1, hitC2, hitRH, hitRL, hitFl, hitAny;
  logic enable, goBit, isRc, swStart, hwStart, swStop, abortNow, goSet;
  logic [3:0] trgCode;
  logic [31:0] rdMux;
  logic halfTick;
  sac_seq_if seqBus();

  // Channel code decode for the channelConnected output
  function automatic logic chanDecode(input logic [4:0] code);
    chanDecode = (code <= 5'h07) || (code >= 5'h1D);
  endfunction

  // ****************************************************************
  // APB slave: one wait state, registered answer
  // ****************************************************************
  assign apbSetup = psel && penable && !pready;
  assign apbDo = psel && penable && pready;
  assign wrEn = apbDo && pwrite;
  assign hitC0 = (paddr == ADDR_W'(`SAC_OFF_CTRL0));
  assign hitC1 = (paddr == ADDR_W'(`SAC_OFF_CTRL1));
  assign hitC2 = (paddr == ADDR_W'(`SAC_OFF_CTRL2));
  assign hitRH = (paddr == ADDR_W'(`SAC_OFF_RESH));
  assign hitRL = (paddr == ADDR_W'(`SAC_OFF_RESL));
  assign hitFl = (paddr == ADDR_W'(`SAC_OFF_FLAG));
  assign hitAny = hitC0 || hitC1 || hitC2 || hitRH || hitRL || hitFl;

  // Read selection; unmapped addresses read zero
  always_comb begin
    rdMux = 32'h0000_0000;
    if (hitC0) begin
      rdMux = {24'h000000, ctrl0_q};
    end else if (hitC1) begin
      rdMux = {24'h000000, ctrl1_q};
    end else if (hitC2) begin
      rdMux = {24'h000000, ctrl2_q};
    end else if (hitRH) begin
      rdMux = {24'h000000, resHigh_q};
    end else if (hitRL) begin
      rdMux = {24'h000000, resLow_q};
    end else if (hitFl) begin
      rdMux = {31'h0000_0000, flag_q};
    end
  end

  // Bus answer flops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= apbSetup;
      pslverr <= apbSetup && !hitAny;
      if (apbSetup && !pwrite) prdata <= rdMux;
    end
  end

  // ****************************************************************
  // Conversion start, stop and abort
  // ****************************************************************
  assign enable = ctrl0_q[`SAC_C0_ENABLE];
  assign goBit = ctrl0_q[`SAC_C0_GO];
  assign isRc = (ctrl1_q[`SAC_C1_CLK_LO +: 2] == 2'h3);
  assign trgCode = ctrl2_q[`SAC_C2_TRG_HI:`SAC_C2_TRG_LO];
  // Code zero selects nothing, so the edge detector never fires
  assign auto_trigger_sel = (trgCode == 4'h0) ? 1'b0 : trigSrc[trgCode];
  assign trigEdge = auto_trigger_sel && !trigPrev_q;
  // Start only from an already enabled module, so the go bit of a combined write is ignored
  assign swStart = wrEn && hitC0 && pwdata[`SAC_C0_GO] && enable && !goBit;
  assign hwStart = trigEdge && enable && !goBit;
  assign swStop = wrEn && hitC0 && !pwdata[`SAC_C0_GO] && goBit;
  // Disable or sleep on a system clock divider kills the conversion
  assign abortNow = goBit && ((wrEn && hitC0 && !pwdata[`SAC_C0_ENABLE]) ||
                              (sleepMode && !isRc));
  assign goSet = swStart || hwStart;

  assign seqBus.start = goSet && !sleepOff_q;
  assign seqBus.stop = swStop && !abortNow;
  assign seqBus.abort = abortNow;

  // Control register next values; unimplemented bits masked off
  always_comb begin
    ctrl0_d = ctrl0_q;
    ctrl1_d = ctrl1_q;
    ctrl2_d = ctrl2_q;
    if (wrEn && hitC0) ctrl0_d = pwdata[7:0] & `SAC_MASK_CTRL0;
    if (wrEn && hitC1) ctrl1_d = pwdata[7:0] & `SAC_MASK_CTRL1;
    if (wrEn && hitC2) ctrl2_d = pwdata[7:0] & `SAC_MASK_CTRL2;
    ctrl0_d[`SAC_C0_GO] = goBit;
    if (seqBus.complete || abortNow || swStop) ctrl0_d[`SAC_C0_GO] = 1'b0;
    if (goSet && !abortNow) ctrl0_d[`SAC_C0_GO] = 1'b1;
    if (sleepOff_q && goSet) ctrl0_d[`SAC_C0_GO] = 1'b0;
  end

  // ****************************************************************
  // Result formatting and completion flag
  // ****************************************************************
  assign resHigh_d = ctrl1_q[`SAC_C1_FMT] ? {6'h00, seqBus.result[9:8]} :
                     seqBus.result[9:2];
  assign resLow_d = ctrl1_q[`SAC_C1_FMT] ? seqBus.result[7:0] :
                    {seqBus.result[1:0], 6'h00};
  // Hardware set wins over a software clear in the same cycle
  assign flag_d = seqBus.complete ||
                  (flag_q && !(wrEn && hitFl && pwdata[`SAC_FLAG_DONE]));
  // Power-down in sleep holds until sleep ends; enable bit untouched
  assign sleepOff_d = sleepMode && (sleepOff_q || !isRc ||
                      (seqBus.complete && !convIntEnable));

  // Register file and flag
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl0_q <= `SAC_RST_CTRL0;
      ctrl1_q <= `SAC_RST_CTRL1;
      ctrl2_q <= `SAC_RST_CTRL2;
      resHigh_q <= 8'h00;
      resLow_q <= 8'h00;
      flag_q <= 1'b0;
      sleepOff_q <= 1'b0;
      trigPrev_q <= 1'b0;
    end else begin
      ctrl0_q <= ctrl0_d;
      ctrl1_q <= ctrl1_d;
      ctrl2_q <= ctrl2_d;
      flag_q <= flag_d;
      sleepOff_q <= sleepOff_d;
      trigPrev_q <= auto_trigger_sel;
      if (seqBus.resultLoad) begin
        resHigh_q <= resHigh_d;
        resLow_q <= resLow_d;
      end
    end
  end

  // ****************************************************************
  // Analog-facing outputs, all registered
  // ****************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      channelSel <= 5'h00;
      channelConnected <= 1'b0;
      posRefSel <= 2'h0;
      refValid <= 1'b0;
      analogPowered <= 1'b0;
      sampleHold <= 1'b0;
      convDoneFlag <= 1'b0;
      wakeReq <= 1'b0;
      dacTrial <= 10'h000;
    end else begin
      channelSel <= ctrl0_q[`SAC_C0_CHS_HI:`SAC_C0_CHS_LO];
      channelConnected <= chanDecode(ctrl0_q[`SAC_C0_CHS_HI:`SAC_C0_CHS_LO]);
      posRefSel <= ctrl1_q[`SAC_C1_REF_HI:`SAC_C1_REF_LO];
      refValid <= (ctrl1_q[`SAC_C1_REF_HI:`SAC_C1_REF_LO] != 2'h1);
      analogPowered <= enable && !sleepOff_q;
      sampleHold <= seqBus.busy;
      convDoneFlag <= flag_d;
      wakeReq <= seqBus.complete && sleepMode && convIntEnable;
      dacTrial <= seqBus.trial;
    end
  end

  // ****************************************************************
  // Conversion clock and sequencer
  // ****************************************************************
  // RC source keeps ticking in sleep, so the conversion runs on
  sac_conv_clk #(
    .CNT_W(6)
  ) uClk (
    .clk(clk),
    .rst(rst),
    .run(seqBus.busy),
    .clkSel(ctrl1_q[`SAC_C1_CLK_HI:`SAC_C1_CLK_LO]),
    .rcClkPin(rcClkPin),
    .halfTick(halfTick)
  );

  sac_sar_seq uSeq (
    .clk(clk),
    .rst(rst),
    .halfTick(halfTick),
    .cmpAbove(cmpAbove),
    .port(seqBus.seq)
  );
endmodule // sac_top

/* shared/sac_cfg.svh */
`ifndef SAC_CFG_SVH
`define SAC_CFG_SVH

// ****************************************************************
// Register byte offsets on the APB
// ****************************************************************
`define SAC_OFF_CTRL0 8'h00
`define SAC_OFF_CTRL1 8'h04
`define SAC_OFF_CTRL2 8'h08
`define SAC_OFF_RESH 8'h0C
`define SAC_OFF_RESL 8'h10
`define SAC_OFF_FLAG 8'h14

// ****************************************************************
// Field positions
// ****************************************************************
`define SAC_C0_ENABLE 0
`define SAC_C0_GO 1
`define SAC_C0_CHS_LO 2
`define SAC_C0_CHS_HI 6
`define SAC_C1_FMT 7
`define SAC_C1_CLK_LO 4
`define SAC_C1_CLK_HI 6
`define SAC_C1_REF_LO 0
`define SAC_C1_REF_HI 1
`define SAC_C2_TRG_LO 4
`define SAC_C2_TRG_HI 7
`define SAC_FLAG_DONE 0

// ****************************************************************
// Reset values and writable masks
// ****************************************************************
`define SAC_RST_CTRL0 8'h00
`define SAC_RST_CTRL1 8'h00
`define SAC_RST_CTRL2 8'h00
`define SAC_MASK_CTRL0 8'h7F
`define SAC_MASK_CTRL1 8'hF3
`define SAC_MASK_CTRL2 8'hF0

// ****************************************************************
// Conversion timing: setup in conversion clock half periods, result bit count, half-period lengths in system clocks
// ****************************************************************
`define SAC_SETUP_HALVES 3
`define SAC_RES_BITS 10
`define SAC_HALF_DIV2 6'h01
`define SAC_HALF_DIV4 6'h02
`define SAC_HALF_DIV8 6'h04
`define SAC_HALF_DIV16 6'h08
`define SAC_HALF_DIV32 6'h10
`define SAC_HALF_DIV64 6'h20

`endif

/* shared/sac_pkg.sv */
// ****************************************************************
// Types shared by the converter control files
// ****************************************************************
package sac_pkg;

  typedef logic [9:0] sac_result_t;

  // Sequencer states, Gray coded along idle, setup, try, decide
  typedef enum logic [1:0] {
    SAC_IDLE = 2'b00,
    SAC_SETUP = 2'b01,
    SAC_TRY = 2'b11,
    SAC_DECIDE = 2'b10
  } sac_state_e;

  // Conversion clock select codes
  typedef enum logic [2:0] {
    SAC_CLK_DIV2 = 3'h0,
    SAC_CLK_DIV8 = 3'h1,
    SAC_CLK_DIV32 = 3'h2,
    SAC_CLK_RC_A = 3'h3,
    SAC_CLK_DIV4 = 3'h4,
    SAC_CLK_DIV16 = 3'h5,
    SAC_CLK_DIV64 = 3'h6,
    SAC_CLK_RC_B = 3'h7
  } sac_clk_sel_e;

endpackage

/* shared/sac_seq_if.sv */
`timescale 1ns/100ps
// ****************************************************************
// Control and result path between top and sequencer
// ****************************************************************
interface sac_seq_if;
  logic start;
  logic stop;
  logic abort;
  logic busy;
  logic resultLoad;
  logic complete;
  sac_pkg::sac_result_t result;
  sac_pkg::sac_result_t trial;

  modport ctrl (output start, output stop, output abort,
    input busy, input resultLoad, input complete, input result, input trial);
  modport seq (input start, input stop, input abort,
    output busy, output resultLoad, output complete, output result, output trial);
endinterface

/* sim/sac_top_checker.sv */
`timescale 1ns/100ps
`include "sac_cfg.svh"
// ********
// Port-level checks on the converter control block
// ********
module sac_top_checker #(
  parameter int ADDR_W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sleepMode,
  input wire logic convIntEnable,
  input wire logic [4:0] channelSel,
  input wire logic channelConnected,
  input wire logic [1:0] posRefSel,
  input wire logic refValid,
  input wire logic analogPowered,
  input wire logic sampleHold,
  input wire logic convDoneFlag,
  input wire logic wakeReq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Completed bus accesses, decoded once
  wire logic [7:0] a8 = 8'(paddr);
  wire logic done = psel && penable && pready;
  wire logic rdDone = done && !pwrite;
  wire logic ctrlWr = done && pwrite && a8 == `SAC_OFF_CTRL0;
  wire logic enOff = ctrlWr && !pwdata[0];
  wire logic stopWr = ctrlWr && pwdata[1:0] == 2'b01;
  // Setup then first access cycle; the answer follows one wait state later
  sequence accessSeq;
    psel && !penable ##1 psel && penable && !pready;
  endsequence
  // A stop that lands while a conversion is still running
  sequence stopHit;
    stopWr && sampleHold && !convDoneFlag;
  endsequence
  apb_wait_a: assert property (accessSeq |=> pready ##1 !pready)
    else $error("pready not after one wait state");
  bad_addr_a: assert property (pslverr |-> pready && !(a8 inside {`SAC_OFF_CTRL0,
    `SAC_OFF_CTRL1, `SAC_OFF_CTRL2, `SAC_OFF_RESH, `SAC_OFF_RESL, `SAC_OFF_FLAG}))
    else $error("error response on a mapped address");
  rst_clear_a: assert property ($fell(rst) |-> !sampleHold && !convDoneFlag
    && !analogPowered && !wakeReq && !pready)
    else $error("outputs not cleared by reset");
  power_off_a: assert property (enOff |-> ##[1:4] (!analogPowered && !sampleHold))
    else $error("converter still powered after disable");
  stop_noflag_a: assert property (stopHit |=> !convDoneFlag [*3])
    else $error("flag set by an early stop");
  flag_src_a: assert property ($rose(convDoneFlag) |-> sampleHold || $past(sampleHold)
    || $past(sampleHold, 2) || $past(sampleHold, 3))
    else $error("flag set without a conversion");
  wake_pulse_a: assert property (wakeReq |-> sleepMode && convIntEnable ##1 !wakeReq)
    else $error("wake request out of place");
  chan_map_a: assert property (!$past(rst) && $stable(channelSel) |->
    channelConnected == (channelSel <= 5'h07 || channelSel >= 5'h1D))
    else $error("channel connection wrong");
  ref_map_a: assert property (!$past(rst) && $stable(posRefSel) |->
    refValid == (posRefSel != 2'h1))
    else $error("reference validity wrong");
  read_zero_a: assert property (rdDone |-> prdata[31:8] == 24'h0
    && !(a8 == `SAC_OFF_CTRL0 && prdata[7])
    && !(a8 == `SAC_OFF_CTRL1 && prdata[3:2] != 2'h0)
    && !(a8 == `SAC_OFF_CTRL2 && prdata[3:0] != 4'h0))
    else $error("unimplemented bits read nonzero");
endmodule // sac_top_checker

bind sac_top sac_top_checker #(.ADDR_W(ADDR_W)) u_checker (.clk, .rst, .paddr, .psel,
  .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .sleepMode, .convIntEnable,
  .channelSel, .channelConnected, .posRefSel, .refValid, .analogPowered, .sampleHold,
  .convDoneFlag, .wakeReq);

/* sim/testbench.sv */
`timescale 1ns/100ps
`include "sac_cfg.svh"
// ********
// Self-checking bench for the converter control block
// ********
module testbench;
  typedef struct {logic [31:0] d; logic e;} sac_exp_s;
  logic clk, rst, psel, penable, pwrite, sleepMode, convIntEnable;
  logic rcClkPin = 1'b0, cmpAbove = 1'b0;
  logic pready, pslverr, channelConnected, refValid, analogPowered, sampleHold;
  logic convDoneFlag, wakeReq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rh, rl, junk;
  logic [15:1] trigSrc;
  logic [9:0] dacTrial, target;
  logic [4:0] channelSel;
  logic [1:0] posRefSel;
  int mismatches, n_compared, seed, n, h, k;
  int rcCnt = 0;
  sac_exp_s expQ[$];
  sac_exp_s got;

  sac_top u_dut (.clk, .rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .trigSrc, .sleepMode, .convIntEnable, .rcClkPin, .cmpAbove, .dacTrial,
    .channelSel, .channelConnected, .posRefSel, .refValid, .analogPowered, .sampleHold,
    .convDoneFlag, .wakeReq);

  // System clock, 50 ns period
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Slow RC clock stand-in; ideal comparator, so a full conversion yields the target
  always @(posedge clk) begin
    rcCnt <= rcCnt + 1;
    if (rcCnt % 5 == 4) rcClkPin <= ~rcClkPin;
    cmpAbove <= target >= dacTrial;
  end

  // Read answers are matched against the oldest expectation
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && expQ.size() > 0) begin
      got = expQ.pop_front();
      cmpW(prdata, got.d);
      cmpB(pslverr, got.e);
    end
  end

  task automatic cmpW(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("FAIL at %0t: got %h, expected %h", $time, g, e);
    end
  endtask

  task automatic cmpB(input logic g, input logic e);
    cmpW({31'h0, g}, {31'h0, e});
  endtask

  // One APB transfer; request held until pready is seen, then an idle cycle
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd,
    output logic [31:0] r);
    int t;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge clk);
      t++;
    end while (pready !== 1'b1 && t < 100);
    // A bus that never answers counts against the run
    if (pready !== 1'b1) mismatches++;
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d, junk);
  endtask

  task automatic rdx(input logic [7:0] a, input logic [31:0] d, input logic e = 1'b0);
    sac_exp_s x;
    x.d = d;
    x.e = e;
    expQ.push_back(x);
    apb(a, 1'b0, 32'h0, junk);
  endtask

  // Cycles until the converter has run and gone idle, then let results land
  task automatic conv(output int c);
    c = 0;
    while (sampleHold !== 1'b1 && c < 20) begin
      @(posedge clk);
      c++;
    end
    while (sampleHold === 1'b1 && c < 3000) begin
      @(posedge clk);
      c++;
    end
    repeat (3) @(posedge clk);
  endtask

  // True if r is t cut after some decided bit, the rest copying that bit
  function automatic logic isPart(input logic [9:0] r, input logic [9:0] t);
    logic [9:0] p;
    logic ok;
    ok = r === 10'h0;
    for (int j = 1; j <= 10; j++) begin
      p = t;
      for (int i = 0; i < 10 - j; i++) p[i] = t[10-j];
      ok |= r === p;
    end
    return ok;
  endfunction

  task automatic finish_test();
    if (mismatches == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Hang guard, far beyond the few thousand cycles the run needs
  initial begin
    #2000000;
    mismatches++;
    finish_test();
  end

  // Main sequence
  initial begin
    seed = 32'hDDE3EFCC;
    rst = 1'b1;
    {psel, penable, pwrite, sleepMode, convIntEnable} = 5'h00;
    {paddr, pwdata, trigSrc, target, mismatches, n_compared} = '0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdx(`SAC_OFF_CTRL0, 32'h0);
    rdx(`SAC_OFF_CTRL1, 32'h0);
    rdx(`SAC_OFF_CTRL2, 32'h0);
    rdx(8'h18, 32'h0, 1'b1);
    wr(`SAC_OFF_CTRL1, 32'hFF);
    rdx(`SAC_OFF_CTRL1, 32'hF3);
    wr(`SAC_OFF_CTRL2, 32'hFF);
    rdx(`SAC_OFF_CTRL2, 32'hF0);
    wr(`SAC_OFF_CTRL0, 32'hFF);
    rdx(`SAC_OFF_CTRL0, 32'h7D);
    wr(`SAC_OFF_RESH, 32'hFF);
    rdx(`SAC_OFF_RESH, 32'h0);
    // Every channel code and every reference code
    for (k = 0; k < 32; k++) begin
      wr(`SAC_OFF_CTRL0, 32'({k[4:0], 2'b01}));
      wr(`SAC_OFF_CTRL1, 32'(k % 4));
      @(posedge clk);
      cmpB(channelConnected, k < 8 || k > 28);
      cmpW(32'(channelSel), 32'(k[4:0]));
      cmpB(refValid, k % 4 != 1);
      cmpW(32'(posRefSel), 32'(k % 4));
    end
    // Full conversions on every divider; fast ones keep an all-ones code
    for (k = 0; k < 7; k++) begin
      if (k == 3) continue;
      h = (k < 4) ? (1 << (2 * k)) : (2 << (2 * k - 8));
      target = (h < 4) ? 10'h3FF : 10'($random(seed));
      wr(`SAC_OFF_CTRL1, 32'({k[0], k[2:0], 4'h0}));
      wr(`SAC_OFF_FLAG, 32'h1);
      wr(`SAC_OFF_CTRL0, 32'h3);
      conv(n);
      cmpB(n >= 23 * h && n <= 23 * h + 8, 1'b1);
      cmpB(convDoneFlag, 1'b1);
      rdx(`SAC_OFF_CTRL0, 32'h1);
      rdx(`SAC_OFF_FLAG, 32'h1);
      rdx(`SAC_OFF_RESH, k[0] ? 32'(target[9:8]) : 32'(target[9:2]));
      rdx(`SAC_OFF_RESL, k[0] ? 32'(target[7:0]) : 32'({target[1:0], 6'h0}));
    end
    // Early stop on the slowest divider: partial result, no flag
    target = 10'($random(seed));
    wr(`SAC_OFF_CTRL1, 32'hE0);
    wr(`SAC_OFF_FLAG, 32'h1);
    wr(`SAC_OFF_CTRL0, 32'h3);
    repeat (200) @(posedge clk);
    rdx(`SAC_OFF_CTRL0, 32'h3);
    wr(`SAC_OFF_CTRL0, 32'h1);
    repeat (3) @(posedge clk);
    apb(`SAC_OFF_RESH, 1'b0, 32'h0, rh);
    apb(`SAC_OFF_RESL, 1'b0, 32'h0, rl);
    cmpB(isPart({rh[1:0], rl[7:0]}, target), 1'b1);
    rdx(`SAC_OFF_FLAG, 32'h0);
    // Sleep on the RC clock with interrupt: runs on and wakes the core
    target = 10'($random(seed));
    wr(`SAC_OFF_CTRL1, 32'hF0);
    wr(`SAC_OFF_CTRL0, 32'h3);
    sleepMode <= 1'b1;
    convIntEnable <= 1'b1;
    n = 0;
    while (wakeReq !== 1'b1 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    cmpB(wakeReq, 1'b1);
    sleepMode <= 1'b0;
    repeat (4) @(posedge clk);
    rdx(`SAC_OFF_RESH, 32'(target[9:8]));
    rdx(`SAC_OFF_RESL, 32'(target[7:0]));
    // Sleep on the RC clock without interrupt: power down once done
    convIntEnable <= 1'b0;
    wr(`SAC_OFF_CTRL1, 32'h30);
    wr(`SAC_OFF_CTRL0, 32'h3);
    sleepMode <= 1'b1;
    conv(n);
    cmpB(analogPowered, 1'b0);
    rdx(`SAC_OFF_CTRL0, 32'h1);
    sleepMode <= 1'b0;
    repeat (3) @(posedge clk);
    cmpB(analogPowered, 1'b1);
    // Sleep on a divided clock aborts; so does switching the module off
    wr(`SAC_OFF_FLAG, 32'h1);
    wr(`SAC_OFF_CTRL1, 32'h10);
    for (k = 0; k < 2; k++) begin
      wr(`SAC_OFF_CTRL0, 32'h3);
      repeat (20) @(posedge clk);
      if (k == 0) sleepMode <= 1'b1;
      else wr(`SAC_OFF_CTRL0, 32'h0);
      repeat (5) @(posedge clk);
      cmpB(sampleHold, 1'b0);
      cmpB(analogPowered, 1'b0);
      rdx(`SAC_OFF_CTRL0, 32'(1 - k));
      rdx(`SAC_OFF_FLAG, 32'h0);
      sleepMode <= 1'b0;
      wr(`SAC_OFF_CTRL0, 32'h1);
    end
    // Each trigger code starts once, on its own source only; code 0 never
    target = 10'h3FF;
    wr(`SAC_OFF_CTRL1, 32'h0);
    for (k = 0; k < 16; k++) begin
      wr(`SAC_OFF_CTRL2, 32'(k << 4));
      wr(`SAC_OFF_FLAG, 32'h1);
      trigSrc <= 15'h7FFF ^ 15'(k > 0 ? 1 << (k - 1) : 0);
      repeat (4) @(posedge clk);
      cmpB(sampleHold, 1'b0);
      if (k > 0) begin
        trigSrc[k] <= 1'b1;
        conv(n);
        rdx(`SAC_OFF_FLAG, 32'h1);
        repeat (10) @(posedge clk);
        cmpB(sampleHold, 1'b0);
      end
      trigSrc <= 15'h0;
      @(posedge clk);
    end
    // Reset in mid-conversion clears everything
    wr(`SAC_OFF_CTRL1, 32'h60);
    wr(`SAC_OFF_CTRL0, 32'h3);
    repeat (50) @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    cmpB(sampleHold, 1'b0);
    rdx(`SAC_OFF_CTRL0, 32'h0);
    rdx(`SAC_OFF_CTRL1, 32'h0);
    rdx(`SAC_OFF_RESH, 32'h0);
    finish_test();
  end
endmodule // testbench
